//--- hdl/sfa_defines.svh
/*
 Opcodes, reset values and timing counts of the flash command block.
 Assumes mode-0 style framing: select low, data sampled on rising clock.
*/
`ifndef SFA_DEFINES_SVH
`define SFA_DEFINES_SVH

`define SFA_OP_WR_EN 8'h06
`define SFA_OP_WR_DIS 8'h04
`define SFA_OP_SR1_RD 8'h05
`define SFA_OP_SR1_WR 8'h01
`define SFA_OP_RST_EN 8'h66
`define SFA_OP_RST_GO 8'h99
`define SFA_OP_ADDR4_ON 8'hB7
`define SFA_OP_ADDR4_OFF 8'hE9
`define SFA_OP_XADDR_RD 8'hC8
`define SFA_OP_XADDR_WR 8'hC5
`define SFA_OP_FAST_RD 8'h0B

`define SFA_SR1_RST 8'h00
`define SFA_XADDR_RST 8'h00
`define SFA_ADDR_RST 32'h0000_0000
`define SFA_NB_NARROW 3'h3
`define SFA_NB_WIDE 3'h4
`define SFA_TX_MAX 3'h5
`define SFA_RX_MAX 3'h4

// Link clock half period in system clocks
`define SFA_SCK_HALF 4'h2

`endif

//--- hdl/sfa_pkg.sv
/*
 Types shared by both ends of the flash command link.
 Assumes the constants header is included where numbers are needed.
*/
package sfa_pkg;

    typedef struct packed {
        logic [2:0] bit_cnt;
        logic [2:0] byte_cnt;
        logic [7:0] op;
        logic [7:0] sh_in;
        logic [31:0] abuf;
        logic [7:0] tx_sh;
        logic miso;
    } sfa_frm_t;

    typedef struct packed {
        logic addr4;
        logic [7:0] xaddr;
        logic [7:0] sr1;
        logic wel;
        logic rst_armed;
        logic [31:0] acc_addr;
    } sfa_per_t;

    typedef enum logic [2:0] {
        H_IDLE,
        H_LOW,
        H_HIGH,
        H_TAIL,
        H_GAP
    } sfa_hstate_t;

    typedef struct packed {
        sfa_hstate_t st;
        logic [3:0] div;
        logic [6:0] bit_idx;
        logic [6:0] n_bits;
        logic [6:0] rx_start;
        logic [47:0] tx_sh;
        logic [31:0] rx_sh;
        logic s1;
        logic s2;
        logic sck;
        logic cs_n;
        logic mosi;
        logic ready;
        logic rsp_valid;
        logic [31:0] rsp_data;
        logic err;
        logic wren_sent;
        logic rsten_sent;
        logic addr4;
        logic [7:0] xaddr;
    } sfa_host_t;

endpackage

//--- hdl/sfa_if.sv
/*
 Serial link between the flash controller and the flash command block.
 Assumes the bench joins the two modports; no pin is two-way.
*/
`timescale 1ns/1ps
interface sfa_if;
    logic sck;
    logic cs_n;
    logic mosi;
    logic miso;
    modport host (output sck, output cs_n, output mosi, input miso);
    modport dev (input sck, input cs_n, input mosi, output miso);
endinterface

//--- hdl/sfa_dev.sv
/*
 Flash end: command decoding, address width mode, extended address byte,
 status byte with write enable, two-step soft reset.
 Assumes it runs on the link clock; select high clears frame state.
*/
`timescale 1ns/1ps
`include "sfa_defines.svh"
module sfa_dev import sfa_pkg::*; (
    // Link
    sfa_if.dev lnk,
    // Reset and enable
    input wire logic resetn,
    input wire logic ce,
    // Memory side
    input wire logic [7:0] mem_rdata,
    output logic [31:0] acc_addr,
    // Mode and register view
    output logic addr4_mode,
    output logic [7:0] xaddr,
    output logic [7:0] sr1,
    output logic wel
);

    sfa_frm_t frm_q;
    sfa_frm_t frm_d;
    sfa_per_t per_q;
    sfa_per_t per_d;
    logic frm_rst_n;
    logic [7:0] rxb;
    logic [7:0] out;
    logic [2:0] nab;
    logic [31:0] abuf;

    // Frame state ends with the frame itself
    assign frm_rst_n = resetn & ~lnk.cs_n;

    assign lnk.miso = frm_q.miso;
    assign acc_addr = per_q.acc_addr;
    assign addr4_mode = per_q.addr4;
    assign xaddr = per_q.xaddr;
    assign sr1 = per_q.sr1;
    assign wel = per_q.wel;

    always_comb
    begin
        frm_d = frm_q;
        per_d = per_q;
        out = 8'h00;
        rxb = {frm_q.sh_in[6:0], lnk.mosi};
        nab = per_q.addr4 ? `SFA_NB_WIDE : `SFA_NB_NARROW;
        abuf = {frm_q.abuf[23:0], rxb};
        if (ce)
        begin
            frm_d.sh_in = rxb;
            frm_d.bit_cnt = frm_q.bit_cnt + 3'h1;
            if (frm_q.bit_cnt == 3'h7)
            begin
                if (frm_q.byte_cnt != 3'h7)
                begin
                    frm_d.byte_cnt = frm_q.byte_cnt + 3'h1;
                end
                if (frm_q.byte_cnt == 3'h0)
                begin
                    // Opcode byte
                    frm_d.op = rxb;
                    per_d.rst_armed = (rxb == `SFA_OP_RST_EN);
                    case (rxb)
                        `SFA_OP_WR_EN:
                        begin
                            per_d.wel = 1'b1;
                        end
                        `SFA_OP_WR_DIS:
                        begin
                            per_d.wel = 1'b0;
                        end
                        `SFA_OP_SR1_RD:
                        begin
                            out = per_q.sr1;
                        end
                        `SFA_OP_RST_GO:
                        begin
                            if (per_q.rst_armed)
                            begin
                                // Status byte is persistent and survives this
                                per_d.addr4 = 1'b0;
                                per_d.xaddr = `SFA_XADDR_RST;
                                per_d.wel = 1'b0;
                                per_d.acc_addr = `SFA_ADDR_RST;
                            end
                        end
                        `SFA_OP_ADDR4_ON:
                        begin
                            per_d.addr4 = 1'b1;
                        end
                        `SFA_OP_ADDR4_OFF:
                        begin
                            // Latch state is not consulted here
                            per_d.addr4 = 1'b0;
                        end
                        `SFA_OP_XADDR_RD:
                        begin
                            out = per_q.xaddr;
                        end
                        default:
                        begin
                            out = 8'h00;
                        end
                    endcase
                end
                else
                begin
                    // Bytes after the opcode
                    case (frm_q.op)
                        `SFA_OP_SR1_WR:
                        begin
                            if ((frm_q.byte_cnt == 3'h1) && per_q.wel)
                            begin
                                per_d.sr1 = rxb;
                                per_d.wel = 1'b0;
                            end
                        end
                        `SFA_OP_XADDR_WR:
                        begin
                            // Only the first data byte is taken
                            if (frm_q.byte_cnt == 3'h1)
                            begin
                                per_d.xaddr = rxb;
                            end
                        end
                        `SFA_OP_XADDR_RD:
                        begin
                            out = per_q.xaddr;
                        end
                        `SFA_OP_SR1_RD:
                        begin
                            out = per_q.sr1;
                        end
                        `SFA_OP_FAST_RD:
                        begin
                            if (frm_q.byte_cnt <= nab)
                            begin
                                frm_d.abuf = abuf;
                                if (frm_q.byte_cnt == nab)
                                begin
                                    if (per_q.addr4)
                                    begin
                                        per_d.acc_addr = abuf;
                                    end
                                    else
                                    begin
                                        per_d.acc_addr = {per_q.xaddr, abuf[23:0]};
                                    end
                                end
                            end
                            else
                            begin
                                // Dummy byte done, then one byte per byte
                                out = mem_rdata;
                                per_d.acc_addr = per_q.acc_addr + 32'h0000_0001;
                            end
                        end
                        default:
                        begin
                            out = 8'h00;
                        end
                    endcase
                end
                frm_d.miso = out[7];
                frm_d.tx_sh = {out[6:0], 1'b0};
            end
            else
            begin
                frm_d.miso = frm_q.tx_sh[7];
                frm_d.tx_sh = {frm_q.tx_sh[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge lnk.sck or negedge frm_rst_n)
    begin
        if (!frm_rst_n)
        begin
            frm_q <= '0;
        end
        else
        begin
            frm_q <= frm_d;
        end
    end

    always_ff @(posedge lnk.sck or negedge resetn)
    begin
        if (!resetn)
        begin
            per_q.addr4 <= 1'b0;
            per_q.xaddr <= `SFA_XADDR_RST;
            per_q.sr1 <= `SFA_SR1_RST;
            per_q.wel <= 1'b0;
            per_q.rst_armed <= 1'b0;
            per_q.acc_addr <= `SFA_ADDR_RST;
        end
        else
        begin
            per_q <= per_d;
        end
    end

endmodule

//--- hdl/sfa_host.sv
/*
 Controller end: frames one command with up to five bytes out and four in,
 makes the link clock by division, keeps a mirror of the address mode.
 Assumes the flash answers one bit ahead, changing data on rising edges.
*/
`timescale 1ns/1ps
`include "sfa_defines.svh"
module sfa_host import sfa_pkg::*; (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic ce,
    // Link
    sfa_if.host lnk,
    // Command
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_op,
    input wire logic [39:0] cmd_tx,
    input wire logic [2:0] cmd_tx_len,
    input wire logic [2:0] cmd_rx_len,
    output logic cmd_ready,
    output logic cmd_err,
    // Answer
    output logic rsp_valid,
    output logic [31:0] rsp_data,
    // Mode mirror
    output logic addr4_mode,
    output logic [7:0] xaddr
);

    sfa_host_t q;
    sfa_host_t d;
    logic [2:0] txl;
    logic [2:0] rxl;
    logic [3:0] tot;
    logic [3:0] txp;
    logic half_done;

    assign lnk.sck = q.sck;
    assign lnk.cs_n = q.cs_n;
    assign lnk.mosi = q.mosi;
    assign cmd_ready = q.ready;
    assign cmd_err = q.err;
    assign rsp_valid = q.rsp_valid;
    assign rsp_data = q.rsp_data;
    assign addr4_mode = q.addr4;
    assign xaddr = q.xaddr;

    always_comb
    begin
        d = q;
        // Extended address write carries exactly one byte
        if (cmd_op == `SFA_OP_XADDR_WR)
        begin
            txl = 3'h1;
        end
        else if (cmd_tx_len > `SFA_TX_MAX)
        begin
            txl = `SFA_TX_MAX;
        end
        else
        begin
            txl = cmd_tx_len;
        end
        rxl = (cmd_rx_len > `SFA_RX_MAX) ? `SFA_RX_MAX : cmd_rx_len;
        txp = {1'b0, txl} + 4'h1;
        tot = txp + {1'b0, rxl};
        half_done = (q.div == (`SFA_SCK_HALF - 4'h1));
        if (ce)
        begin
            d.s1 = lnk.miso;
            d.s2 = q.s1;
            d.rsp_valid = 1'b0;
            d.err = 1'b0;
            d.div = half_done ? 4'h0 : q.div + 4'h1;
            case (q.st)
                H_IDLE:
                begin
                    d.div = 4'h0;
                    if (cmd_valid && q.ready)
                    begin
                        if (((cmd_op == `SFA_OP_SR1_WR) && !q.wren_sent) ||
                            ((cmd_op == `SFA_OP_RST_GO) && !q.rsten_sent))
                        begin
                            d.err = 1'b1;
                        end
                        else
                        begin
                            d.st = H_LOW;
                            d.ready = 1'b0;
                            d.cs_n = 1'b0;
                            d.bit_idx = 7'h00;
                            d.n_bits = {tot, 3'h0};
                            d.rx_start = {txp, 3'h0};
                            d.tx_sh = {cmd_op, cmd_tx};
                            d.mosi = cmd_op[7];
                            d.rx_sh = 32'h0000_0000;
                            d.rsten_sent = (cmd_op == `SFA_OP_RST_EN);
                            if (cmd_op == `SFA_OP_WR_EN)
                            begin
                                d.wren_sent = 1'b1;
                            end
                            else if ((cmd_op == `SFA_OP_WR_DIS) || (cmd_op == `SFA_OP_SR1_WR))
                            begin
                                d.wren_sent = 1'b0;
                            end
                            if (cmd_op == `SFA_OP_ADDR4_ON)
                            begin
                                d.addr4 = 1'b1;
                            end
                            else if (cmd_op == `SFA_OP_ADDR4_OFF)
                            begin
                                d.addr4 = 1'b0;
                            end
                            else if (cmd_op == `SFA_OP_RST_GO)
                            begin
                                d.addr4 = 1'b0;
                                d.xaddr = `SFA_XADDR_RST;
                                d.wren_sent = 1'b0;
                            end
                            else if (cmd_op == `SFA_OP_XADDR_WR)
                            begin
                                d.xaddr = cmd_tx[39:32];
                            end
                        end
                    end
                end
                H_LOW:
                begin
                    if (half_done)
                    begin
                        if (q.bit_idx >= q.rx_start)
                        begin
                            d.rx_sh = {q.rx_sh[30:0], q.s2};
                        end
                        d.sck = 1'b1;
                        d.st = H_HIGH;
                    end
                end
                H_HIGH:
                begin
                    if (half_done)
                    begin
                        d.sck = 1'b0;
                        d.bit_idx = q.bit_idx + 7'h01;
                        d.tx_sh = {q.tx_sh[46:0], 1'b0};
                        d.mosi = q.tx_sh[46];
                        d.st = (q.bit_idx == (q.n_bits - 7'h01)) ? H_TAIL : H_LOW;
                    end
                end
                H_TAIL:
                begin
                    if (half_done)
                    begin
                        d.cs_n = 1'b1;
                        d.mosi = 1'b0;
                        d.rsp_valid = 1'b1;
                        d.rsp_data = q.rx_sh;
                        d.st = H_GAP;
                    end
                end
                H_GAP:
                begin
                    if (half_done)
                    begin
                        d.ready = 1'b1;
                        d.st = H_IDLE;
                    end
                end
                default:
                begin
                    d.st = H_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            q <= '0;
            q.st <= H_IDLE;
            q.cs_n <= 1'b1;
            q.ready <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

endmodule

//--- verification/sfa_monitor.sv
/*
 Link checker: decodes opcodes on the wire and tracks the device state it implies.
 Assumes the host makes sck from sys_clk, idles it low and frames with cs_n.
*/
`timescale 1ns/1ps
`include "sfa_defines.svh"
module sfa_monitor (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Link
    input wire logic sck,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso
);
    logic [6:0] cnt_q;
    logic [6:0] sh_q;
    logic [7:0] op_q;
    logic [7:0] xa_q;
    logic [7:0] sr_q;
    logic wel_q;
    logic arm_q;
    logic [7:0] byte_w;

    assign byte_w = {sh_q, mosi};

    // Bit count of the current frame
    always_ff @(posedge sck or posedge cs_n)
    begin
        if (cs_n)
            cnt_q <= 7'h00;
        else
            cnt_q <= cnt_q + 7'h01;
    end

    // Device state as implied by the commands seen
    always_ff @(posedge sck or negedge resetn)
    begin
        if (!resetn)
            {op_q, xa_q, sr_q, wel_q, arm_q, sh_q} <= '0;
        else if (!cs_n)
        begin
            sh_q <= byte_w[6:0];
            if (cnt_q == 7'h07)
            begin
                op_q <= byte_w;
                arm_q <= (byte_w == `SFA_OP_RST_EN);
                if (byte_w == `SFA_OP_WR_EN)
                    wel_q <= 1'b1;
                if (byte_w == `SFA_OP_WR_DIS)
                    wel_q <= 1'b0;
                if (byte_w == `SFA_OP_RST_GO && arm_q)
                    {xa_q, wel_q} <= '0;
            end
            if (cnt_q == 7'h0F && op_q == `SFA_OP_XADDR_WR)
                xa_q <= byte_w;
            if (cnt_q == 7'h0F && op_q == `SFA_OP_SR1_WR && wel_q)
                {sr_q, wel_q} <= {byte_w, 1'b0};
        end
    end

    a_status_readback:
    assert property (@(posedge sck) disable iff (!resetn) !cs_n && op_q == `SFA_OP_SR1_RD
        && cnt_q[6:3] == 4'h1 |-> miso == sr_q[~cnt_q[2:0]]) else $error("status byte bit wrong");
    a_xaddr_readback:
    assert property (@(posedge sck) disable iff (!resetn) !cs_n && op_q == `SFA_OP_XADDR_RD
        && cnt_q[6:3] == 4'h1 |-> miso == xa_q[~cnt_q[2:0]]) else $error("extended byte bit wrong");
    a_wrsr_after_wren:
    assert property (@(posedge sck) disable iff (!resetn) !cs_n && cnt_q == 7'h07
        && byte_w == `SFA_OP_SR1_WR |-> wel_q) else $error("status write sent without enable");
    a_reset_after_enable:
    assert property (@(posedge sck) disable iff (!resetn) !cs_n && cnt_q == 7'h07
        && byte_w == `SFA_OP_RST_GO |-> arm_q) else $error("reset sent without reset enable");
    a_c5_single_byte:
    assert property (@(posedge sys_clk) disable iff (!resetn) $rose(cs_n)
        && op_q == `SFA_OP_XADDR_WR |-> $past(cnt_q) == 7'h10) else $error("extended write length");
    a_single_byte_ops:
    assert property (@(posedge sys_clk) disable iff (!resetn) $rose(cs_n) && op_q inside
        {`SFA_OP_WR_EN, `SFA_OP_WR_DIS, `SFA_OP_RST_EN, `SFA_OP_RST_GO, `SFA_OP_ADDR4_ON,
        `SFA_OP_ADDR4_OFF} |-> $past(cnt_q) == 7'h08) else $error("opcode frame not one byte");
    a_whole_bytes:
    assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(cs_n) |-> $past(cnt_q[2:0]) == 3'h0) else $error("frame ends in mid byte");
    a_miso_released:
    assert property (@(posedge sys_clk) disable iff (!resetn)
        cs_n && $past(cs_n) |-> !miso) else $error("miso driven outside frame");

    c_xaddr_read: cover property (@(posedge sck) op_q == `SFA_OP_XADDR_RD && cnt_q == 7'h0F);
    c_soft_reset: cover property (@(posedge sck) cnt_q == 7'h07 && byte_w == `SFA_OP_RST_GO);
    c_wide_entry: cover property (@(posedge sck) cnt_q == 7'h07 && byte_w == `SFA_OP_ADDR4_ON);
endmodule

//--- verification/sfa_tb_top.sv
/*
 Bench joining host and device through the link; issues commands, checks both views.
 Assumes the package, header and design files are compiled first.
*/
`timescale 1ns/1ps
`include "sfa_defines.svh"
`define CHK_EQ(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin fails++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, gt); end end
module sfa_tb_top;
    logic sys_clk;
    logic resetn;
    logic cmd_valid;
    logic [7:0] cmd_op;
    logic [39:0] cmd_tx;
    logic [2:0] cmd_tx_len;
    logic [2:0] cmd_rx_len;
    logic cmd_ready;
    logic cmd_err;
    logic rsp_valid;
    logic [31:0] rsp_data;
    logic h_addr4;
    logic [7:0] h_xaddr;
    logic [7:0] mem_rdata;
    logic [31:0] d_acc;
    logic d_addr4;
    logic [7:0] d_xaddr;
    logic [7:0] d_sr1;
    logic d_wel;
    logic seen_err;
    int fails;
    int checks;

    sfa_if sfa_if_i ();
    sfa_host sfa_host_i (.sys_clk(sys_clk), .resetn(resetn), .ce(1'b1), .lnk(sfa_if_i.host),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_tx(cmd_tx), .cmd_tx_len(cmd_tx_len),
        .cmd_rx_len(cmd_rx_len), .cmd_ready(cmd_ready), .cmd_err(cmd_err),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .addr4_mode(h_addr4), .xaddr(h_xaddr));
    sfa_dev sfa_dev_i (.lnk(sfa_if_i.dev), .resetn(resetn), .ce(1'b1), .mem_rdata(mem_rdata),
        .acc_addr(d_acc), .addr4_mode(d_addr4), .xaddr(d_xaddr), .sr1(d_sr1), .wel(d_wel));
    sfa_monitor sfa_monitor_i (.sys_clk(sys_clk), .resetn(resetn), .sck(sfa_if_i.sck),
        .cs_n(sfa_if_i.cs_n), .mosi(sfa_if_i.mosi), .miso(sfa_if_i.miso));

    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // Memory contents follow the access address
    always @(posedge sys_clk) mem_rdata <= d_acc[7:0] ^ 8'hA5;

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic run_cmd(input logic [7:0] op, input logic [39:0] tx,
        input logic [2:0] txl, input logic [2:0] rxl);
        int n;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (cmd_ready !== 1'b1 && n < 1000);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_tx <= tx;
        cmd_tx_len <= txl;
        cmd_rx_len <= rxl;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (cmd_err !== 1'b1 && rsp_valid !== 1'b1 && n < 1000);
        seen_err = (cmd_err === 1'b1);
        `CHK_EQ("command completion", 1'b1, n < 1000)
    endtask

    task automatic end_test(input string nm);
        $display("test %s done", nm);
    endtask

    initial
    begin
        resetn = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = 8'h00;
        cmd_tx = 40'h0;
        cmd_tx_len = 3'h0;
        cmd_rx_len = 3'h0;
        fails = 0;
        checks = 0;
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        run_cmd(`SFA_OP_XADDR_RD, 40'h0, 3'h0, 3'h1);
        `CHK_EQ("xaddr at reset", 8'h00, rsp_data[7:0])
        `CHK_EQ("addr4 at reset", 1'b0, d_addr4)
        end_test("defaults");
        run_cmd(`SFA_OP_SR1_WR, 40'h3C_0000_0000, 3'h1, 3'h0);
        `CHK_EQ("status write refused", 1'b1, seen_err)
        run_cmd(`SFA_OP_WR_EN, 40'h0, 3'h0, 3'h0);
        `CHK_EQ("wel set", 1'b1, d_wel)
        run_cmd(`SFA_OP_SR1_WR, 40'h3C_0000_0000, 3'h1, 3'h0);
        run_cmd(`SFA_OP_SR1_RD, 40'h0, 3'h0, 3'h1);
        `CHK_EQ("status byte", 8'h3C, rsp_data[7:0])
        `CHK_EQ("wel after write", 1'b0, d_wel)
        end_test("status");
        // Extra bytes after the first must not count
        run_cmd(`SFA_OP_XADDR_WR, 40'hA7_1122_0000, 3'h3, 3'h0);
        run_cmd(`SFA_OP_XADDR_RD, 40'h0, 3'h0, 3'h1);
        `CHK_EQ("xaddr read", 8'hA7, rsp_data[7:0])
        `CHK_EQ("dev xaddr", 8'hA7, d_xaddr)
        `CHK_EQ("host xaddr", 8'hA7, h_xaddr)
        // Memory model returns address low byte xor A5
        run_cmd(`SFA_OP_FAST_RD, 40'h12_3456_0000, 3'h4, 3'h1);
        `CHK_EQ("narrow address", 24'hA7_1234, d_acc[31:8])
        `CHK_EQ("narrow data", 8'hF3, rsp_data[7:0])
        end_test("extended byte");
        run_cmd(`SFA_OP_ADDR4_ON, 40'h0, 3'h0, 3'h0);
        `CHK_EQ("dev wide mode", 1'b1, d_addr4)
        `CHK_EQ("host wide mode", 1'b1, h_addr4)
        run_cmd(`SFA_OP_FAST_RD, 40'h01_2345_6700, 3'h5, 3'h1);
        `CHK_EQ("wide address", 24'h01_2345, d_acc[31:8])
        `CHK_EQ("wide data", 8'hC2, rsp_data[7:0])
        `CHK_EQ("no enable before exit", 1'b0, d_wel)
        run_cmd(`SFA_OP_ADDR4_OFF, 40'h0, 3'h0, 3'h0);
        `CHK_EQ("exit accepted", 1'b0, seen_err)
        `CHK_EQ("dev narrow mode", 1'b0, d_addr4)
        `CHK_EQ("host narrow mode", 1'b0, h_addr4)
        end_test("address width");
        run_cmd(`SFA_OP_XADDR_WR, 40'h0, 3'h1, 3'h0);
        run_cmd(`SFA_OP_FAST_RD, 40'hAB_CDEF_0000, 3'h4, 3'h1);
        `CHK_EQ("lowest segment", 24'h00_ABCD, d_acc[31:8])
        `CHK_EQ("lowest data", 8'h4A, rsp_data[7:0])
        end_test("lowest segment");
        run_cmd(`SFA_OP_ADDR4_ON, 40'h0, 3'h0, 3'h0);
        run_cmd(`SFA_OP_XADDR_WR, 40'h5A_0000_0000, 3'h1, 3'h0);
        run_cmd(`SFA_OP_RST_GO, 40'h0, 3'h0, 3'h0);
        `CHK_EQ("bare reset refused", 1'b1, seen_err)
        run_cmd(`SFA_OP_RST_EN, 40'h0, 3'h0, 3'h0);
        run_cmd(`SFA_OP_WR_DIS, 40'h0, 3'h0, 3'h0);
        run_cmd(`SFA_OP_RST_GO, 40'h0, 3'h0, 3'h0);
        `CHK_EQ("split reset refused", 1'b1, seen_err)
        `CHK_EQ("mode kept", 1'b1, d_addr4)
        run_cmd(`SFA_OP_RST_EN, 40'h0, 3'h0, 3'h0);
        run_cmd(`SFA_OP_RST_GO, 40'h0, 3'h0, 3'h0);
        `CHK_EQ("soft reset mode", 1'b0, d_addr4)
        `CHK_EQ("soft reset xaddr", 8'h00, d_xaddr)
        `CHK_EQ("host mirror mode", 1'b0, h_addr4)
        `CHK_EQ("host mirror xaddr", 8'h00, h_xaddr)
        `CHK_EQ("status kept", 8'h3C, d_sr1)
        end_test("soft reset");
        run_cmd(`SFA_OP_ADDR4_ON, 40'h0, 3'h0, 3'h0);
        run_cmd(`SFA_OP_XADDR_WR, 40'h33_0000_0000, 3'h1, 3'h0);
        `CHK_EQ("wide before reset", 1'b1, d_addr4)
        resetn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        run_cmd(`SFA_OP_XADDR_RD, 40'h0, 3'h0, 3'h1);
        `CHK_EQ("hard reset xaddr", 8'h00, rsp_data[7:0])
        `CHK_EQ("hard reset mode", 1'b0, d_addr4)
        `CHK_EQ("hard reset host", 1'b0, h_addr4)
        end_test("hard reset");
        close_out();
    end

    initial
    begin
        #2_000_000;
        fails++;
        $display("[ERR] watchdog expected finish seen hang");
        close_out();
    end
endmodule
